/* rtl/ric_remote_interface_control.sv */
// FIFO and top level of the remote interface control block
`timescale 1ns/1ps
`include "ric_cfg.svh"

// Small synchronous FIFO with valid/ready on both sides
module ric_fifo #(
    parameter int WIDTH = `RIC_FIFO_WIDTH,
    parameter int DEPTH = `RIC_FIFO_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic             flush,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    logic             push;
    logic             pop;

    assign inReady  = (count_q != (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData  = mem[rdPtr_q];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    // Storage
    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem[wrPtr_q] <= inData;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || flush)
        begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (pop)
            begin
                rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : ric_fifo

module ric_remote_interface_control (
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    input  wire logic              ifReset,
    input  wire logic              cfgWr,
    input  wire ric_pkg::ric_cfg_t cfgIn,
    output ric_pkg::ric_cfg_t      cfgOut,
    output logic                   talkOnly,
    output logic                   dataBits8,
    input  wire logic              gpibRxValid,
    input  wire logic [7:0]        gpibRxData,
    input  wire logic              gpibRxEoi,
    input  wire logic              gpibDevClear,
    input  wire logic              gpibTalkAddr,
    output logic                   gpibTxValid,
    input  wire logic              gpibTxReady,
    output logic      [7:0]        gpibTxData,
    output logic                   gpibTxEoi,
    input  wire logic              serRxValid,
    input  wire logic [7:0]        serRxData,
    input  wire logic              serRemote,
    output logic                   serTxValid,
    input  wire logic              serTxReady,
    output logic      [7:0]        serTxData,
    output logic                   serDtr,
    output logic                   cmdValid,
    output ric_pkg::ric_char_t     cmdChar,
    input  wire logic              cmdReady,
    output logic                   cmdFlush,
    input  wire logic              calReq,
    output logic                   calExec,
    output logic                   calIgnored,
    output logic                   calRefused,
    output logic                   abortMeas,
    output logic                   trigIdle,
    input  wire logic              rdgValid,
    output logic                   rdgReady,
    input  wire ric_pkg::ric_rdg_t rdg,
    input  wire logic              qryValid,
    output logic                   qryReady,
    input  wire ric_pkg::ric_char_t qry
);
    import ric_pkg::*;

    typedef enum logic [1:0] {FMT_IDLE, FMT_RDG, FMT_QRY, FMT_TERM} ric_fmt_t;
    typedef enum logic [1:0] {LC_IDLE, LC_GOT_L, LC_GOT_N} ric_lc_t;

    ric_cfg_t   cfg_q;
    ric_fmt_t   fmt_q;
    ric_lc_t    lc_q;
    ric_lang_t  lcLang_q;
    logic [4:0] rdgIdx_q;
    logic [6:0] qryCnt_q;
    ric_rdg_t   rdgHold_q;
    logic       dtr_q;
    logic       devClear;
    logic       rxValid;
    logic [7:0] rxData;
    logic       rxEnd;
    logic       isTerm;
    logic       fifoInValid;
    logic       fifoInReady;
    ric_char_t  fifoIn;
    logic       fifoOutValid;
    logic       fifoOutReady;
    ric_char_t  fifoOut;
    logic       txAllowed;
    logic       txReady;

    // BCD digit to ASCII character
    function automatic logic [7:0] digitChar(input logic [3:0] d);
        digitChar = `RIC_CH_ZERO + {4'h0, d};
    endfunction : digitChar

    // Sign to ASCII character
    function automatic logic [7:0] signChar(input logic neg);
        signChar = neg ? `RIC_CH_MINUS : `RIC_CH_PLUS;
    endfunction : signChar

    // Character at a position of the fixed reading format
    function automatic logic [7:0] rdgChar(input ric_rdg_t r, input logic [4:0] idx);
        logic [3:0] mIdx;
        mIdx = 4'h0;
        rdgChar = `RIC_CH_ZERO;
        unique case (idx)
            `RIC_POS_SIGN:  rdgChar = signChar(r.neg);
            `RIC_POS_LEAD:  rdgChar = digitChar(r.mant[35:32]);
            `RIC_POS_DOT:   rdgChar = `RIC_CH_DOT;
            `RIC_POS_EXP:   rdgChar = `RIC_CH_E;
            `RIC_POS_ESIGN: rdgChar = signChar(r.expNeg);
            `RIC_POS_EHI:   rdgChar = digitChar(r.expo[7:4]);
            `RIC_POS_ELO:   rdgChar = digitChar(r.expo[3:0]);
            default:
            begin
                mIdx = 4'(idx - `RIC_POS_DOT);
                rdgChar = digitChar(r.mant[35 - 4*mIdx -: 4]);
            end
        endcase
    endfunction : rdgChar

    // Configuration outputs
    assign cfgOut    = cfg_q;
    assign talkOnly  = (cfg_q.addr == `RIC_ADDR_TALK_ONLY);
    assign dataBits8 = (cfg_q.parity == RIC_PAR_NONE);

    // Settings: factory defaults at power-up, untouched by clears and interface reset
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            cfg_q.addr    <= `RIC_ADDR_DEFAULT;
            cfg_q.portSel <= RIC_PORT_GPIB;
            cfg_q.baud    <= `RIC_BAUD_DEFAULT;
            cfg_q.parity  <= RIC_PAR_EVEN;
            cfg_q.lang    <= RIC_LANG_NATIVE;
        end
        else if (cfgWr)
        begin
            // Out-of-range codes keep the old value
            cfg_q.addr    <= cfgIn.addr;
            cfg_q.portSel <= cfgIn.portSel;
            if (cfgIn.baud <= `RIC_BAUD_MAX)
            begin
                cfg_q.baud <= cfgIn.baud;
            end
            if (cfgIn.parity != `RIC_CODE_BAD)
            begin
                cfg_q.parity <= cfgIn.parity;
            end
            if (cfgIn.lang != `RIC_CODE_BAD)
            begin
                cfg_q.lang <= cfgIn.lang;
            end
        end
        else if (lc_q == LC_GOT_N && rxValid && isTerm && !cmdFlush)
        begin
            cfg_q.lang <= lcLang_q;
        end
    end

    // Receive path from the selected port only
    assign rxValid  = (cfg_q.portSel == RIC_PORT_GPIB) ? gpibRxValid : serRxValid;
    assign rxData   = (cfg_q.portSel == RIC_PORT_GPIB) ? gpibRxData : serRxData;
    assign rxEnd    = (cfg_q.portSel == RIC_PORT_GPIB) & gpibRxEoi;
    assign isTerm   = (rxData == `RIC_CH_NL) | rxEnd;
    assign devClear = ((cfg_q.portSel == RIC_PORT_GPIB) & gpibDevClear)
                    | ((cfg_q.portSel == RIC_PORT_SERIAL) & serRxValid
                       & (serRxData == `RIC_CH_CTRLC));

    // Command characters to the parser; CR dropped, NL or EOI marks the end
    assign cmdValid     = rxValid & ~devClear & (rxData != `RIC_CH_CR);
    assign cmdChar.data = rxData;
    assign cmdChar.last = isTerm;

    // Clear actions; configuration and status are left alone, no self-test
    assign cmdFlush  = devClear | ifReset;
    assign abortMeas = devClear | ifReset;
    assign trigIdle  = devClear | ifReset;

    // Language command detector on the command stream
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || devClear || ifReset)
        begin
            lc_q     <= LC_IDLE;
            lcLang_q <= RIC_LANG_NATIVE;
        end
        else if (rxValid && rxData != `RIC_CH_CR)
        begin
            unique case (lc_q)
                LC_IDLE:  lc_q <= (rxData == `RIC_CH_L) ? LC_GOT_L : LC_IDLE;
                LC_GOT_L:
                begin
                    lc_q <= LC_GOT_N;
                    if (rxData == `RIC_CH_ONE)
                    begin
                        lcLang_q <= RIC_LANG_NATIVE;
                    end
                    else if (rxData == `RIC_CH_TWO)
                    begin
                        lcLang_q <= RIC_LANG_COMPAT_A;
                    end
                    else if (rxData == `RIC_CH_THREE)
                    begin
                        lcLang_q <= RIC_LANG_COMPAT_B;
                    end
                    else
                    begin
                        lc_q <= LC_IDLE;
                    end
                end
                LC_GOT_N: lc_q <= LC_IDLE;
            endcase
            if (isTerm && lc_q != LC_GOT_N)
            begin
                lc_q <= LC_IDLE;
            end
        end
    end

    // Calibration gate by language
    assign calExec    = calReq & (cfg_q.lang == RIC_LANG_NATIVE);
    assign calIgnored = calReq & (cfg_q.lang == RIC_LANG_COMPAT_A);
    assign calRefused = calReq & (cfg_q.lang == RIC_LANG_COMPAT_B);

    // DTR true after any clear or interface reset, then follows input readiness
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || devClear || ifReset)
        begin
            dtr_q <= 1'b1;
        end
        else
        begin
            dtr_q <= cmdReady;
        end
    end
    assign serDtr = dtr_q;

    // Output formatter: readings and query answers into the FIFO
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || devClear || ifReset)
        begin
            fmt_q     <= FMT_IDLE;
            rdgIdx_q  <= '0;
            qryCnt_q  <= '0;
            rdgHold_q <= '0;
        end
        else
        begin
            unique case (fmt_q)
                FMT_IDLE:
                begin
                    rdgIdx_q <= '0;
                    qryCnt_q <= '0;
                    if (rdgValid)
                    begin
                        rdgHold_q <= rdg;
                        fmt_q     <= FMT_RDG;
                    end
                    else if (qryValid)
                    begin
                        fmt_q <= FMT_QRY;
                    end
                end
                FMT_RDG:
                begin
                    if (fifoInReady)
                    begin
                        rdgIdx_q <= rdgIdx_q + 5'h01;
                        if (rdgIdx_q == `RIC_RDG_LEN)
                        begin
                            fmt_q <= FMT_IDLE;
                        end
                    end
                end
                FMT_QRY:
                begin
                    if (qryValid && fifoInReady)
                    begin
                        qryCnt_q <= qryCnt_q + 7'h01;
                        if (qry.last || qryCnt_q == `RIC_QRY_MAX - 7'h01)
                        begin
                            fmt_q <= qry.last ? FMT_IDLE : FMT_TERM;
                        end
                    end
                end
                FMT_TERM:
                begin
                    // Swallow the cut tail of an over-long answer
                    if (qryValid && qry.last)
                    begin
                        fmt_q <= FMT_IDLE;
                    end
                end
            endcase
        end
    end

    // Formatter outputs into the FIFO and back-pressure to sources
    always_comb
    begin
        fifoInValid = 1'b0;
        fifoIn      = '0;
        rdgReady    = 1'b0;
        qryReady    = 1'b0;
        unique case (fmt_q)
            FMT_IDLE: ;
            FMT_RDG:
            begin
                fifoInValid = 1'b1;
                if (rdgIdx_q == `RIC_RDG_LEN)
                begin
                    // Comma between readings, port terminator after the last
                    fifoIn.data = rdgHold_q.more ? `RIC_CH_COMMA :
                                  ((cfg_q.portSel == RIC_PORT_GPIB) ? `RIC_CH_NL : `RIC_CH_CR);
                    fifoIn.last = ~rdgHold_q.more;
                    rdgReady    = fifoInReady;
                end
                else
                begin
                    fifoIn.data = rdgChar(rdgHold_q, rdgIdx_q);
                end
            end
            FMT_QRY:
            begin
                fifoInValid = qryValid;
                qryReady    = fifoInReady;
                fifoIn.data = qry.data;
                fifoIn.last = qry.last | (qryCnt_q == `RIC_QRY_MAX - 7'h01);
            end
            FMT_TERM: qryReady = 1'b1;
        endcase
    end

    // Output buffer, emptied by any clear
    ric_fifo #(
        .WIDTH   (`RIC_FIFO_WIDTH),
        .DEPTH   (`RIC_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .flush   (devClear | ifReset),
        .inValid (fifoInValid),
        .inReady (fifoInReady),
        .inData  (fifoIn),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData (fifoOut)
    );

    // Transmit only on the selected port; talk-only needs no addressing
    assign txAllowed    = (cfg_q.portSel == RIC_PORT_GPIB) ? (gpibTalkAddr | talkOnly)
                                                           : (serRemote | talkOnly);
    assign txReady      = (cfg_q.portSel == RIC_PORT_GPIB) ? gpibTxReady : serTxReady;
    assign fifoOutReady = txAllowed & txReady;
    assign gpibTxValid  = fifoOutValid & txAllowed & (cfg_q.portSel == RIC_PORT_GPIB);
    assign serTxValid   = fifoOutValid & txAllowed & (cfg_q.portSel == RIC_PORT_SERIAL);
    assign gpibTxData   = fifoOut.data;
    assign gpibTxEoi    = fifoOut.last;
    assign serTxData    = fifoOut.data;
endmodule : ric_remote_interface_control

/* rtl/ric_cfg.svh */
// Constants of the remote interface control block
`ifndef RIC_CFG_SVH
`define RIC_CFG_SVH
`define RIC_ADDR_DEFAULT   5'h16
`define RIC_ADDR_TALK_ONLY 5'h1F
`define RIC_BAUD_DEFAULT   3'h5
`define RIC_BAUD_MAX       3'h5
`define RIC_RDG_LEN        5'h0F
`define RIC_POS_SIGN       5'h00
`define RIC_POS_LEAD       5'h01
`define RIC_POS_DOT        5'h02
`define RIC_POS_EXP        5'h0B
`define RIC_POS_ESIGN      5'h0C
`define RIC_POS_EHI        5'h0D
`define RIC_POS_ELO        5'h0E
`define RIC_CODE_BAD       2'h3
`define RIC_QRY_MAX        7'h4F
`define RIC_CH_NL          8'h0A
`define RIC_CH_CR          8'h0D
`define RIC_CH_CTRLC       8'h03
`define RIC_CH_COMMA       8'h2C
`define RIC_CH_PLUS        8'h2B
`define RIC_CH_MINUS       8'h2D
`define RIC_CH_DOT         8'h2E
`define RIC_CH_E           8'h45
`define RIC_CH_L           8'h4C
`define RIC_CH_ZERO        8'h30
`define RIC_CH_ONE         8'h31
`define RIC_CH_TWO         8'h32
`define RIC_CH_THREE       8'h33
`define RIC_FIFO_DEPTH     4
`define RIC_FIFO_WIDTH     9
`endif

/* rtl/ric_pkg.sv */
// Types of the remote interface control block
`include "ric_cfg.svh"
package ric_pkg;
    typedef enum logic {RIC_PORT_GPIB, RIC_PORT_SERIAL} ric_port_t;
    typedef enum logic [1:0] {RIC_PAR_NONE, RIC_PAR_EVEN, RIC_PAR_ODD} ric_parity_t;
    typedef enum logic [1:0] {RIC_LANG_NATIVE, RIC_LANG_COMPAT_A, RIC_LANG_COMPAT_B} ric_lang_t;
    typedef struct packed {
        logic [4:0]  addr;
        ric_port_t   portSel;
        logic [2:0]  baud;     // 0..5 = 300,600,1200,2400,4800,9600
        ric_parity_t parity;
        ric_lang_t   lang;
    } ric_cfg_t;
    typedef struct packed {
        logic       neg;
        logic [35:0] mant;     // Nine BCD digits, most significant first
        logic       expNeg;
        logic [7:0] expo;      // Two BCD digits
        logic       more;      // Another reading follows
    } ric_rdg_t;
    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } ric_char_t;
endpackage : ric_pkg

/* verification/ric_host_model.sv */
// Model of the host or listen-always printer on one remote port
`timescale 1ns/1ps
module ric_host_model (
    input  wire logic       clk_sys,
    input  wire logic       clr,
    input  wire logic       slow,
    input  wire logic       txValid,
    input  wire logic [7:0] txData,
    input  wire logic       txLast,
    output logic            txReady
);
    logic [7:0] gotByte [0:127];
    int         count;
    int         lastAt;
    logic       phase_q;
    // Always listening, or every other cycle when slow
    assign txReady = !slow || phase_q;
    // Capture each accepted character
    always_ff @(posedge clk_sys)
    begin
        phase_q <= !phase_q && !clr;
        if (clr)
        begin
            count <= 0;
            lastAt <= -1;
        end
        else if (txValid && txReady && count < 128)
        begin
            gotByte[count] <= txData;
            count <= count + 1;
            if (txLast)
                lastAt <= count;
        end
    end
endmodule : ric_host_model

/* verification/ric_rif_monitor.sv */
// Assertion checker of the remote interface control block
`timescale 1ns/1ps
module ric_rif_monitor (
    input wire logic              clk_sys,
    input wire logic              rst_b,
    input wire ric_pkg::ric_cfg_t cfgOut,
    input wire logic              cfgWr,
    input wire logic              talkOnly,
    input wire logic              gpibDevClear,
    input wire logic              gpibTalkAddr,
    input wire logic              gpibTxValid,
    input wire logic              serRxValid,
    input wire logic [7:0]        serRxData,
    input wire logic              serRemote,
    input wire logic              serTxValid,
    input wire logic              serDtr,
    input wire logic              cmdValid,
    input wire logic              cmdFlush,
    input wire logic              calReq,
    input wire logic              calExec,
    input wire logic              calIgnored,
    input wire logic              abortMeas,
    input wire logic              trigIdle
);
    import ric_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // ****
    // Checks
    // ****
    AST_TALK: assert property (talkOnly == (cfgOut.addr == 5'h1F))
        else $error("talk-only flag wrong");
    AST_GPIB_CLR: assert property (cfgOut.portSel == RIC_PORT_GPIB && gpibDevClear
        |-> abortMeas && trigIdle && cmdFlush) else $error("bus clear lost");
    AST_SER_CLR: assert property (cfgOut.portSel == RIC_PORT_SERIAL && serRxValid
        && serRxData == 8'h03 |-> abortMeas && trigIdle && cmdFlush) else $error("serial clear lost");
    AST_DTR: assert property (abortMeas |=> serDtr)
        else $error("handshake not true");
    AST_KEEP: assert property (abortMeas && !cfgWr |=> $stable(cfgOut))
        else $error("clear changed settings");
    AST_FLUSH: assert property (abortMeas |=> !gpibTxValid && !serTxValid)
        else $error("output not flushed");
    AST_IGNORE: assert property (cfgOut.portSel == RIC_PORT_SERIAL && !serRxValid |-> !cmdValid)
        else $error("unselected port forwarded");
    AST_GPIB_TX: assert property (gpibTxValid |-> cfgOut.portSel == RIC_PORT_GPIB
        && (gpibTalkAddr || talkOnly)) else $error("bus sent unasked");
    AST_SER_TX: assert property (serTxValid |-> cfgOut.portSel == RIC_PORT_SERIAL
        && (serRemote || talkOnly)) else $error("serial sent unasked");
    AST_CAL: assert property (calReq && cfgOut.lang == RIC_LANG_COMPAT_A
        |-> calIgnored && !calExec) else $error("calibrate not ignored");
    CV_CLR: cover property (abortMeas);
    CV_CAL: cover property (calIgnored);
    CV_TALK: cover property (serTxValid && talkOnly);
endmodule : ric_rif_monitor
bind ric_remote_interface_control ric_rif_monitor i_ric_rif_monitor (.clk_sys, .rst_b, .cfgOut, .cfgWr,
    .talkOnly, .gpibDevClear, .gpibTalkAddr, .gpibTxValid, .serRxValid, .serRxData, .serRemote, .serTxValid,
    .serDtr, .cmdValid, .cmdFlush, .calReq, .calExec, .calIgnored, .abortMeas, .trigIdle);

/* verification/ric_remote_interface_control_tb.sv */
// Testbench of the remote interface control block
`timescale 1ns/1ps
module ric_remote_interface_control_tb;
    import ric_pkg::*;
    logic clk_sys = 1'h0, rst_b = 1'h0, ifReset = 1'h0, cfgWr = 1'h0, gpibRxValid = 1'h0, gpibRxEoi = 1'h0;
    logic gpibDevClear = 1'h0, gpibTalkAddr = 1'h0, serRxValid = 1'h0, serRemote = 1'h0, cmdReady = 1'h1;
    logic calReq = 1'h0, rdgValid = 1'h0, qryValid = 1'h0, hostClr = 1'h1, hostSlow = 1'h0;
    logic [7:0] gpibRxData = 8'h00, serRxData = 8'h00;
    ric_cfg_t cfgIn = '0, cfgOut, saved;
    ric_rdg_t rdg = '0;
    ric_char_t qry = '0, cmdChar;
    logic talkOnly, dataBits8, gpibTxValid, gpibTxReady, gpibTxEoi, serTxValid, serTxReady, serDtr, cmdValid;
    logic cmdFlush, calExec, calIgnored, calRefused, abortMeas, trigIdle, rdgReady, qryReady;
    logic [7:0] gpibTxData, serTxData;
    int errors = 0, tests_run = 0, cycles = 0, k, n;
    ric_remote_interface_control i_ric_remote_interface_control (.clk_sys, .rst_b, .ifReset, .cfgWr,
        .cfgIn, .cfgOut, .talkOnly, .dataBits8, .gpibRxValid, .gpibRxData, .gpibRxEoi, .gpibDevClear,
        .gpibTalkAddr, .gpibTxValid, .gpibTxReady, .gpibTxData, .gpibTxEoi, .serRxValid, .serRxData,
        .serRemote, .serTxValid, .serTxReady, .serTxData, .serDtr, .cmdValid, .cmdChar, .cmdReady,
        .cmdFlush, .calReq, .calExec, .calIgnored, .calRefused, .abortMeas, .trigIdle, .rdgValid,
        .rdgReady, .rdg, .qryValid, .qryReady, .qry);
    ric_host_model i_host_gpib (.clk_sys, .clr(hostClr), .slow(hostSlow), .txValid(gpibTxValid),
        .txData(gpibTxData), .txLast(gpibTxEoi), .txReady(gpibTxReady));
    ric_host_model i_host_ser (.clk_sys, .clr(hostClr), .slow(hostSlow), .txValid(serTxValid),
        .txData(serTxData), .txLast(1'h0), .txReady(serTxReady));
    // Clock and hang guard
    always #5 clk_sys = !clk_sys;
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            conclude();
        end
    end
    // ****
    // Tasks
    // ****
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    task automatic setCfg(input logic [4:0] a, input ric_port_t p, input ric_parity_t par);
        cfgIn = cfgOut;
        cfgIn.addr = a;
        cfgIn.portSel = p;
        cfgIn.parity = par;
        cfgWr = 1'h1;
        @(negedge clk_sys);
        cfgWr = 1'h0;
        @(negedge clk_sys);
    endtask : setCfg
    task automatic gCmd(input logic [23:0] s);
        gpibRxValid = 1'h1;
        for (int i = 2; i >= 0; i--)
        begin
            gpibRxData = s[i*8 +: 8];
            @(negedge clk_sys);
        end
        gpibRxValid = 1'h0;
        repeat (2) @(negedge clk_sys);
    endtask : gCmd
    task automatic waitHost(input logic ser, input int want);
        for (n = 0; n < 2000 && (ser ? i_host_ser.count : i_host_gpib.count) < want; n++)
            @(negedge clk_sys);
    endtask : waitHost
    task automatic sendRdg(input ric_rdg_t r, input logic ser, input logic [7:0] term);
        logic [7:0] e [16];
        e[0] = r.neg ? 8'h2D : 8'h2B;
        e[2] = 8'h2E;
        for (k = 0; k < 9; k++)
            e[k == 0 ? 1 : k + 2] = {4'h3, r.mant[35 - 4*k -: 4]};
        e[11] = 8'h45;
        e[12] = r.expNeg ? 8'h2D : 8'h2B;
        e[13] = {4'h3, r.expo[7:4]};
        e[14] = {4'h3, r.expo[3:0]};
        e[15] = r.more ? 8'h2C : term;
        hostClr = 1'h1;
        rdg = r;
        rdgValid = 1'h1;
        @(negedge clk_sys);
        hostClr = 1'h0;
        for (k = 0; k < 200 && rdgReady !== 1'h1; k++)
            @(negedge clk_sys);
        @(negedge clk_sys);
        rdgValid = 1'h0;
        waitHost(ser, 16);
        for (k = 0; k < 16; k++)
            chk(ser ? i_host_ser.gotByte[k] : i_host_gpib.gotByte[k], e[k]);
    endtask : sendRdg
    // ****
    // Main sequence
    // ****
    initial
    begin
        repeat (6) @(negedge clk_sys);
        rst_b = 1'h1;
        @(negedge clk_sys);
        chk({cfgOut.addr, cfgOut.portSel, cfgOut.baud}, {5'h16, RIC_PORT_GPIB, 3'h5});
        chk({cfgOut.parity, cfgOut.lang, dataBits8, serDtr}, {RIC_PAR_EVEN, RIC_LANG_NATIVE, 2'h1});
        gpibTalkAddr = 1'h1;
        hostSlow = 1'h1;
        sendRdg({1'h1, 36'h123456789, 1'h1, 8'h05, 1'h0}, 1'h0, 8'h0A);
        chk(i_host_gpib.lastAt, 15);
        sendRdg({1'h0, 36'h900000001, 1'h0, 8'h99, 1'h1}, 1'h0, 8'h0A);
        for (int d = 1; d <= 3; d++)
        begin
            gCmd({8'h4C, 8'h30 + d[7:0], 8'h0A});
            chk(cfgOut.lang, d - 1);
            calReq = 1'h1;
            #1 chk({calExec, calIgnored, calRefused}, {d == 1, d == 2, d == 3});
            @(negedge clk_sys);
            calReq = 1'h0;
        end
        gCmd({8'h4C, 8'h31, 8'h0A});
        gpibRxValid = 1'h1;
        gpibRxData = 8'h0D;
        #1 chk(cmdValid, 0);
        @(negedge clk_sys);
        gpibRxData = 8'h41;
        gpibRxEoi = 1'h1;
        #1 chk({cmdValid, cmdChar}, {1'h1, 8'h41, 1'h1});
        @(negedge clk_sys);
        gpibRxValid = 1'h0;
        gpibRxEoi = 1'h0;
        hostClr = 1'h1;
        qryValid = 1'h1;
        @(negedge clk_sys);
        hostClr = 1'h0;
        for (k = 0, n = 0; k < 90 && n < 2000; n++)
        begin
            qry = {8'h41, k == 89};
            #1 if (qryReady === 1'h1)
                k++;
            @(negedge clk_sys);
        end
        qryValid = 1'h0;
        waitHost(1'h0, 79);
        repeat (10) @(negedge clk_sys);
        chk(i_host_gpib.count, 79);
        chk(i_host_gpib.lastAt, 78);
        gpibTalkAddr = 1'h0;
        saved = cfgOut;
        cmdReady = 1'h0;
        rdgValid = 1'h1;
        repeat (8) @(negedge clk_sys);
        gpibDevClear = 1'h1;
        gpibTalkAddr = 1'h1;
        #1 chk({abortMeas, trigIdle, cmdFlush, serDtr}, 4'hE);
        @(negedge clk_sys);
        gpibDevClear = 1'h0;
        rdgValid = 1'h0;
        #1 chk({gpibTxValid, serDtr, cfgOut}, {2'h1, saved});
        ifReset = 1'h1;
        @(negedge clk_sys);
        ifReset = 1'h0;
        @(negedge clk_sys);
        chk(cfgOut, saved);
        setCfg(5'h1F, RIC_PORT_SERIAL, RIC_PAR_NONE);
        chk({talkOnly, dataBits8}, 2'h3);
        sendRdg({1'h0, 36'h000000042, 1'h1, 8'h12, 1'h0}, 1'h1, 8'h0D);
        chk(i_host_gpib.count, 0);
        gpibRxValid = 1'h1;
        gpibRxData = 8'h4C;
        #1 chk(cmdValid, 0);
        @(negedge clk_sys);
        gpibRxValid = 1'h0;
        serRxValid = 1'h1;
        serRxData = 8'h03;
        #1 chk({abortMeas, trigIdle, cmdFlush}, 3'h7);
        @(negedge clk_sys);
        serRxValid = 1'h0;
        chk(serDtr, 1);
        conclude();
    end
endmodule : ric_remote_interface_control_tb
